// ### hdl/perf_report_pkg.sv
`default_nettype none
package perf_report_pkg;
   // Register offsets (byte addresses)
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] TRIG_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] TICK_OFS = 8'h0c;
   // Control register fields and reset value
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_CCS_LSB = 1;
   localparam int CTRL_CTXOBS_BIT = 3;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   // Trigger register fields and reset value
   localparam int TRIG_THR1_BIT = 0;
   localparam int TRIG_THR2_BIT = 1;
   localparam int TRIG_MMIO_BIT = 2;
   localparam logic [1:0] TRIG_RST = 2'h0;
   // Report header word fields
   localparam int HDR_DELAYED_BIT = 47;
   localparam int HDR_CCS_SEL_LSB = 36;
   localparam int HDR_CCS_ID_LSB = 36;
   localparam int HDR_CCS_ID_W = 11;
   localparam int HDR_SRC_LSB = 26;
   localparam int HDR_CAUSE_LSB = 19;
   localparam int HDR_START_BIT = 18;
   localparam int HDR_THR_BIT = 17;
   localparam int HDR_CTXV_BIT = 16;
   // Cause bits
   localparam int CAUSE_W = 7;
   localparam int CAUSE_TRIG1 = 1;
   localparam int CAUSE_TRIG2 = 2;
   localparam int CAUSE_MMIO = 6;
   // Requester code groups
   localparam logic [2:0] SRC_GRP_OTHER = 3'h0;
   localparam logic [2:0] SRC_GRP_STREAM = 3'h1;
   localparam logic [2:0] SRC_GRP_SHADER = 3'h2;
   localparam logic [2:0] SRC_IDX_HOST = 3'h1;
   localparam logic [2:0] SRC_STREAM_MAX = 3'h2;
   localparam logic [2:0] SRC_SHADER_MAX = 3'h6;
   localparam logic [2:0] SRC_MEDIA_MAX = 3'h2;
   localparam logic [2:0] SRC_COMPUTE_IDX = 3'h1;
   // Record layout
   localparam int HDR_DWORDS = 8;
   localparam int BOOL_CNT = 8;
   localparam int CUST_CNT = 8;

   typedef enum logic [2:0] {
      REQ_OTHER = 3'h0,
      REQ_HOST = 3'h1,
      REQ_STREAMER = 3'h2,
      REQ_SHADER = 3'h3,
      REQ_MEDIA = 3'h4
   } req_class_e;

   typedef struct packed {
      req_class_e cls;
      logic [2:0] index;
      logic [1:0] media_slice;
      logic [10:0] ccs_id;
   } requester_s;

   typedef struct packed {
      logic [31:0] context_tag;
      logic context_valid;
      logic [55:0] elapsed_time;
   } snap_state_s;
endpackage : perf_report_pkg
`default_nettype wire

// ### hdl/render_tick_counter.sv
`default_nettype none
module render_tick_counter
   import perf_report_pkg::*;
#(
   parameter int WIDTH = 32
)
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // Clock state
   input wire logic clocks_gated_i,
   input wire logic deep_idle_i,
   // Count
   output logic [WIDTH-1:0] count_o
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;

   // Frozen, not cleared, while the domain sleeps
   always_comb
   begin
      count_next = count_reg;
      if (!clocks_gated_i && !deep_idle_i)
      begin
         count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         count_reg <= '0;
      end
      else
      begin
         count_reg <= count_next;
      end
   end

   assign count_o = count_reg;
endmodule // render_tick_counter
`default_nettype wire

// ### hdl/requester_encoder.sv
`default_nettype none
module requester_encoder
   import perf_report_pkg::*;
(
   // Requester description
   input wire requester_s req_i,
   // Encoded code
   output logic [5:0] code_o,
   output logic is_compute_o
);
   // Reserved codes never leave here: out of range maps to 0
   always_comb
   begin
      code_o = 6'h00;
      is_compute_o = 1'b0;
      case (req_i.cls)
         REQ_HOST: code_o = {1'b0, SRC_GRP_OTHER[1:0], SRC_IDX_HOST};
         REQ_STREAMER:
         begin
            if (req_i.index <= SRC_STREAM_MAX)
            begin
               code_o = {1'b0, SRC_GRP_STREAM[1:0], req_i.index};
               is_compute_o = (req_i.index == SRC_COMPUTE_IDX);
            end
         end
         REQ_SHADER:
         begin
            if (req_i.index <= SRC_SHADER_MAX)
            begin
               code_o = {1'b0, SRC_GRP_SHADER[1:0], req_i.index};
            end
         end
         REQ_MEDIA:
         begin
            if (req_i.index <= SRC_MEDIA_MAX)
            begin
               code_o = {1'b1, req_i.media_slice, req_i.index};
            end
         end
         default: code_o = 6'h00;
      endcase
   end
endmodule // requester_encoder
`default_nettype wire

// ### hdl/perf_report_header_formatter.sv
// Functional notes
// - Write a snapshot record on a request command or internal trigger firing.
// - Record carries a 32-bit free-running render clock tick count.
// - Tick count follows clock rate and holds while gated or deeply idle.
// - Record carries the 32-bit active context tag.
// - Upper dword of the context slot is reserved zero.
// - Record a 56-bit elapsed time, low dword 31:0, high dword 55:32.
// - Header bit 47 flags a delayed report.
// - Context observation mode puts selected compute streamer id in bits 37:36.
// - Header bits 31:26 hold the 6-bit requester code.
// - Bits 25:19 hold cause: timer, trigger one, trigger two, context switch.
// - Cause bit 4 run-control fall, bit 5 clock ratio, bit 6 register trigger.
// - Bit 18 is start-event status of trigger one or two by cause.
// - Trigger one wins when both set; trigger one is the default.
// - Bit 17 is threshold enable with the same selection as bit 18.
// - Code 000000 for other sources, 000001 for host processor.
// - Streamers use 001xxx, 0 to 2; compute streamer also fills bits 46:36.
// - Shader stages use 010xxx, 0 to 6; 7 reserved.
// - Media sets bit 5, slice in 4:3, streamers 0 to 2.
//
// Our own choices: the plain strobed port and the placing of the registers.
`default_nettype none
module perf_report_header_formatter
   import perf_report_pkg::*;
#(
   parameter int NUM_AGG = 8
)
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Snapshot requests
   input wire logic cmd_req_i,
   input wire requester_s cmd_src_i,
   input wire logic trig_fire_i,
   input wire logic [CAUSE_W-1:0] trig_cause_i,
   input wire logic start_evt1_i,
   input wire logic start_evt2_i,
   // Live state
   input wire snap_state_s live_i,
   input wire logic clocks_gated_i,
   input wire logic deep_idle_i,
   input wire logic [NUM_AGG*32-1:0] agg_cnt_i,
   input wire logic [BOOL_CNT*32-1:0] bool_cnt_i,
   input wire logic [CUST_CNT*32-1:0] cust_cnt_i,
   // Record stream
   output logic rec_valid_o,
   output logic [31:0] rec_data_o,
   output logic rec_last_o,
   input wire logic rec_ready_i,
   output logic busy_o
);
   localparam int REC = HDR_DWORDS + NUM_AGG + BOOL_CNT + CUST_CNT;
   localparam int IW = $clog2(REC);
   localparam logic [IW-1:0] LAST_IDX = IW'(REC - 1);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EMIT = 2'b01,
      ST_DRAIN = 2'b11
   } fmt_state_e;

   // Trigger one wins, and is the default
   function automatic logic pick_trig(input logic [CAUSE_W-1:0] c, input logic v1,
                                      input logic v2);
      pick_trig = (!c[CAUSE_TRIG1] && c[CAUSE_TRIG2]) ? v2 : v1;
   endfunction

   ///////////////////////////////////////////////////////////////////////////
   logic [31:0] ticks;
   logic [5:0] src_code;
   logic src_compute;

   render_tick_counter #(.WIDTH(32)) u_ticks (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .clocks_gated_i(clocks_gated_i),
      .deep_idle_i(deep_idle_i),
      .count_o(ticks)
   );

   requester_encoder u_src (
      .req_i(cmd_src_i),
      .code_o(src_code),
      .is_compute_o(src_compute)
   );

   ///////////////////////////////////////////////////////////////////////////
   // Register file
   logic [31:0] ctrl_reg, ctrl_next;
   logic [1:0] thr_reg, thr_next;
   logic mmio_trig_reg, mmio_trig_next;
   logic [31:0] rdata_reg, rdata_next;
   logic pend_reg, pend_next;
   logic delayed_reg, delayed_next;
   logic [5:0] pend_src_reg, pend_src_next;
   logic pend_cmp_reg, pend_cmp_next;
   logic [CAUSE_W-1:0] pend_cause_reg, pend_cause_next;
   logic [10:0] pend_ccs_reg, pend_ccs_next;
   fmt_state_e state_reg, state_next;

   always_comb
   begin
      ctrl_next = ctrl_reg;
      thr_next = thr_reg;
      mmio_trig_next = 1'b0;
      rdata_next = 32'h0000_0000;
      if (reg_wr_i)
      begin
         case (reg_addr_i)
            CTRL_OFS: ctrl_next = reg_wdata_i;
            TRIG_OFS:
            begin
               thr_next = {reg_wdata_i[TRIG_THR2_BIT], reg_wdata_i[TRIG_THR1_BIT]};
               mmio_trig_next = reg_wdata_i[TRIG_MMIO_BIT];
            end
            default: ctrl_next = ctrl_reg;
         endcase
      end
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            CTRL_OFS: rdata_next = {28'h0, ctrl_reg[3:0]};
            TRIG_OFS: rdata_next = {30'h0, thr_reg};
            STAT_OFS: rdata_next = {29'h0, delayed_reg, pend_reg, state_reg != ST_IDLE};
            TICK_OFS: rdata_next = ticks;
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Request collection; a request meeting a busy formatter is held and marked
   logic req_any;
   logic [CAUSE_W-1:0] req_cause;
   logic take;

   always_comb
   begin
      req_cause = trig_fire_i ? trig_cause_i : '0;
      if (mmio_trig_reg)
      begin
         req_cause[CAUSE_MMIO] = 1'b1;
      end
      req_any = ctrl_reg[CTRL_EN_BIT] && (cmd_req_i || trig_fire_i || mmio_trig_reg);
      take = (state_reg == ST_IDLE) && pend_reg;
      pend_next = pend_reg;
      delayed_next = delayed_reg;
      pend_src_next = pend_src_reg;
      pend_cmp_next = pend_cmp_reg;
      pend_cause_next = pend_cause_reg;
      pend_ccs_next = pend_ccs_reg;
      if (take)
      begin
         pend_next = 1'b0;
         delayed_next = 1'b0;
      end
      // Set wins over the take in the same cycle
      if (req_any)
      begin
         if (pend_reg && !take)
         begin
            delayed_next = 1'b1;
            pend_cause_next = pend_cause_reg | req_cause;
         end
         else
         begin
            pend_next = 1'b1;
            delayed_next = (state_reg != ST_IDLE) && !take;
            pend_cause_next = req_cause;
            pend_src_next = cmd_req_i ? src_code : 6'h00;
            pend_cmp_next = cmd_req_i && src_compute;
            pend_ccs_next = cmd_src_i.ccs_id;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Header and record capture
   logic [63:0] hdr_word;
   logic [31:0] rec_reg [REC];
   logic [31:0] rec_next [REC];

   always_comb
   begin
      hdr_word = 64'h0;
      hdr_word[HDR_DELAYED_BIT] = delayed_reg;
      if (pend_cmp_reg)
      begin
         hdr_word[HDR_CCS_ID_LSB +: HDR_CCS_ID_W] = pend_ccs_reg;
      end
      else if (ctrl_reg[CTRL_CTXOBS_BIT])
      begin
         hdr_word[HDR_CCS_SEL_LSB +: 2] = ctrl_reg[CTRL_CCS_LSB +: 2];
      end
      hdr_word[HDR_SRC_LSB +: 6] = pend_src_reg;
      hdr_word[HDR_CAUSE_LSB +: CAUSE_W] = pend_cause_reg;
      hdr_word[HDR_START_BIT] = pick_trig(pend_cause_reg, start_evt1_i, start_evt2_i);
      hdr_word[HDR_THR_BIT] = pick_trig(pend_cause_reg, thr_reg[0], thr_reg[1]);
      hdr_word[HDR_CTXV_BIT] = live_i.context_valid;
      rec_next = rec_reg;
      if (take)
      begin
         rec_next[0] = hdr_word[31:0];
         rec_next[1] = hdr_word[63:32];
         rec_next[2] = live_i.elapsed_time[31:0];
         rec_next[3] = {8'h00, live_i.elapsed_time[55:32]};
         rec_next[4] = live_i.context_tag;
         rec_next[5] = 32'h0000_0000;
         rec_next[6] = ticks;
         rec_next[7] = 32'h0000_0000;
         for (int i = 0; i < NUM_AGG; i++)
         begin
            rec_next[HDR_DWORDS + i] = agg_cnt_i[i*32 +: 32];
         end
         for (int i = 0; i < BOOL_CNT; i++)
         begin
            rec_next[HDR_DWORDS + NUM_AGG + i] = bool_cnt_i[i*32 +: 32];
         end
         for (int i = 0; i < CUST_CNT; i++)
         begin
            rec_next[HDR_DWORDS + NUM_AGG + BOOL_CNT + i] = cust_cnt_i[i*32 +: 32];
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Output sequencer; the slot holds until the memory side takes it
   logic [IW-1:0] idx_reg, idx_next;
   logic ov_reg, ov_next;
   logic [31:0] od_reg, od_next;
   logic ol_reg, ol_next;

   always_comb
   begin
      state_next = state_reg;
      idx_next = idx_reg;
      ov_next = ov_reg;
      od_next = od_reg;
      ol_next = ol_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (take)
            begin
               idx_next = '0;
               state_next = ST_EMIT;
            end
         end
         ST_EMIT:
         begin
            if (!ov_reg || rec_ready_i)
            begin
               ov_next = 1'b1;
               od_next = rec_reg[idx_reg];
               ol_next = (idx_reg == LAST_IDX);
               idx_next = idx_reg + IW'(1);
               if (idx_reg == LAST_IDX)
               begin
                  state_next = ST_DRAIN;
               end
            end
         end
         ST_DRAIN:
         begin
            if (rec_ready_i)
            begin
               ov_next = 1'b0;
               ol_next = 1'b0;
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   ///////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ctrl_reg <= CTRL_RST;
         thr_reg <= TRIG_RST;
         mmio_trig_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         pend_reg <= 1'b0;
         delayed_reg <= 1'b0;
         pend_src_reg <= 6'h00;
         pend_cmp_reg <= 1'b0;
         pend_cause_reg <= '0;
         pend_ccs_reg <= 11'h000;
         state_reg <= ST_IDLE;
         idx_reg <= '0;
         ov_reg <= 1'b0;
         od_reg <= 32'h0000_0000;
         ol_reg <= 1'b0;
         for (int i = 0; i < REC; i++)
         begin
            rec_reg[i] <= 32'h0000_0000;
         end
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         thr_reg <= thr_next;
         mmio_trig_reg <= mmio_trig_next;
         rdata_reg <= rdata_next;
         pend_reg <= pend_next;
         delayed_reg <= delayed_next;
         pend_src_reg <= pend_src_next;
         pend_cmp_reg <= pend_cmp_next;
         pend_cause_reg <= pend_cause_next;
         pend_ccs_reg <= pend_ccs_next;
         state_reg <= state_next;
         idx_reg <= idx_next;
         ov_reg <= ov_next;
         od_reg <= od_next;
         ol_reg <= ol_next;
         rec_reg <= rec_next;
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign rec_valid_o = ov_reg;
   assign rec_data_o = od_reg;
   assign rec_last_o = ol_reg;
   assign busy_o = (state_reg != ST_IDLE);

   ///////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_take;
      take;
   endsequence
   sequence s_first_dword;
      ##[1:2] (rec_valid_o && !rec_last_o);
   endsequence

   a_take_starts_emit: assert property (s_take |=> state_reg == ST_EMIT)
      else $error("capture did not start emission");
   a_record_begins: assert property (s_take |-> s_first_dword)
      else $error("record did not begin within two cycles");
   a_ctx_hi_zero: assert property (s_take |=> rec_reg[5] == 32'h0)
      else $error("context upper dword not zero");
   a_ticks_hold: assert property ((clocks_gated_i || deep_idle_i) |=> ticks == $past(ticks))
      else $error("tick count moved while gated");
   a_ticks_run: assert property (!clocks_gated_i && !deep_idle_i |=> ticks == $past(ticks) + 32'h1)
      else $error("tick count did not advance");
   a_time_high: assert property (s_take |=> rec_reg[3][31:24] == 8'h00)
      else $error("time high dword upper bits not zero");
   a_delay_flag: assert property (take && delayed_reg |=> rec_reg[1][15] == 1'b1)
      else $error("delayed flag lost");
   a_trig_prio: assert property (take && pend_cause_reg[CAUSE_TRIG1]
                                 |=> rec_reg[0][HDR_START_BIT] == $past(start_evt1_i))
      else $error("trigger one priority broken");
   a_reserved_low: assert property (s_take |=> rec_reg[0][15:0] == 16'h0)
      else $error("reserved header bits set");
   a_last_hold: assert property (rec_valid_o && !rec_ready_i |=> rec_valid_o
                                 && $stable(rec_data_o))
      else $error("stalled dword changed");
endmodule // perf_report_header_formatter
`default_nettype wire

// ### bench/mem_report_sink.sv
`default_nettype none
module mem_report_sink
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // Record stream
   input wire logic rec_valid_i,
   input wire logic [31:0] rec_data_i,
   input wire logic rec_last_i,
   output logic rec_ready_o,
   // Pacing
   input wire logic slow_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] words [0:63];
   int idx;
   int last_at;
   int nrec;
   logic [1:0] phase;
   // Slow pacing accepts one dword in four to hold the formatter busy
   always @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         idx <= 0;
         nrec <= 0;
         last_at <= -1;
         phase <= 2'h0;
         rec_ready_o <= 1'b0;
      end
      else
      begin
         phase <= phase + 2'h1;
         rec_ready_o <= !slow_i || (phase == 2'h2);
         if (rec_valid_i && rec_ready_o)
         begin
            words[idx] <= rec_data_i;
            idx <= rec_last_i ? 0 : idx + 1;
            if (rec_last_i)
            begin
               last_at <= idx;
               nrec <= nrec + 1;
            end
         end
      end
   end
endmodule // mem_report_sink
`default_nettype wire

// ### bench/tb.sv
`default_nettype none
module tb
   import perf_report_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NAGG = 4;
   localparam int REC = 8 + NAGG + 16;
   logic sys_clk_i, resetn_i, reg_wr_i, reg_rd_i, cmd_req_i, trig_fire_i;
   logic [7:0] reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, a, b, tick_exp;
   requester_s cmd_src_i, r;
   logic [CAUSE_W-1:0] trig_cause_i;
   logic start_evt1_i, start_evt2_i, clocks_gated_i, deep_idle_i, slow;
   snap_state_s live_i;
   logic [NAGG*32-1:0] agg_cnt_i;
   logic [BOOL_CNT*32-1:0] bool_cnt_i;
   logic [CUST_CNT*32-1:0] cust_cnt_i;
   logic rec_valid_o, rec_last_o, rec_ready_i, busy_o;
   logic [31:0] rec_data_o;
   logic ctx_mode, thr1, thr2;
   logic [1:0] ccs_sel;
   int error_cnt, compares, nexp;

   perf_report_header_formatter #(.NUM_AGG(NAGG)) u_perf_report_header_formatter (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .cmd_req_i(cmd_req_i), .cmd_src_i(cmd_src_i),
      .trig_fire_i(trig_fire_i), .trig_cause_i(trig_cause_i), .start_evt1_i(start_evt1_i),
      .start_evt2_i(start_evt2_i), .live_i(live_i), .clocks_gated_i(clocks_gated_i),
      .deep_idle_i(deep_idle_i), .agg_cnt_i(agg_cnt_i), .bool_cnt_i(bool_cnt_i),
      .cust_cnt_i(cust_cnt_i), .rec_valid_o(rec_valid_o), .rec_data_o(rec_data_o),
      .rec_last_o(rec_last_o), .rec_ready_i(rec_ready_i), .busy_o(busy_o));
   mem_report_sink u_mem_report_sink (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .rec_valid_i(rec_valid_o),
      .rec_data_i(rec_data_o), .rec_last_i(rec_last_o), .rec_ready_o(rec_ready_i),
      .slow_i(slow));

   initial
   begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      if (error_cnt == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic reg_wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= ad;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] ad, output logic [31:0] d);
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= ad;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask
   task automatic send_cmd(input requester_s q);
      @(posedge sys_clk_i);
      cmd_req_i <= 1'b1;
      cmd_src_i <= q;
      @(posedge sys_clk_i);
      cmd_req_i <= 1'b0;
   endtask
   task automatic send_trig(input logic [6:0] c);
      @(posedge sys_clk_i);
      trig_fire_i <= 1'b1;
      trig_cause_i <= c;
      @(posedge sys_clk_i);
      trig_fire_i <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [5:0] exp_code(input requester_s q);
      case (q.cls)
         REQ_HOST: return 6'h01;
         REQ_STREAMER: return (q.index <= 3'h2) ? {3'h1, q.index} : 6'h00;
         REQ_SHADER: return (q.index <= 3'h6) ? {3'h2, q.index} : 6'h00;
         REQ_MEDIA: return (q.index <= 3'h2) ? {1'b1, q.media_slice, q.index} : 6'h00;
         default: return 6'h00;
      endcase
   endfunction
   function automatic logic [63:0] mk_hdr(input requester_s q, input logic [6:0] c,
                                          input logic dly);
      logic [63:0] h;
      logic use2;
      h = '0;
      use2 = !c[1] && c[2];
      h[47] = dly;
      if (q.cls == REQ_STREAMER && q.index == 3'h1)
         h[46:36] = q.ccs_id;
      else if (ctx_mode)
         h[37:36] = ccs_sel;
      h[31:26] = exp_code(q);
      h[25:19] = c;
      h[18] = use2 ? start_evt2_i : start_evt1_i;
      h[17] = use2 ? thr2 : thr1;
      h[16] = live_i.context_valid;
      return h;
   endfunction
   function automatic logic [31:0] exp_word(input int k);
      case (k)
         2: return live_i.elapsed_time[31:0];
         3: return {8'h00, live_i.elapsed_time[55:32]};
         4: return live_i.context_tag;
         6: return tick_exp;
         5, 7: return 32'h0000_0000;
         default:
            if (k < 8 + NAGG)
               return 32'ha000_0000 + k - 8;
            else if (k < 16 + NAGG)
               return 32'hb000_0000 + k - 8 - NAGG;
            else
               return 32'hc000_0000 + k - 16 - NAGG;
      endcase
   endfunction
   task automatic get_rec(input logic [63:0] hdr);
      int n;
      n = 0;
      nexp++;
      while (u_mem_report_sink.nrec < nexp && n < 3000)
      begin
         @(posedge sys_clk_i);
         #1 n++;
      end
      if (n >= 3000)
      begin
         error_cnt++;
         $display("Error %0t: record missing", $time);
      end
      check(u_mem_report_sink.words[0], hdr[31:0]);
      check(u_mem_report_sink.words[1], hdr[63:32]);
      check(u_mem_report_sink.last_at, REC - 1);
      for (int k = 2; k < REC; k++)
         check(u_mem_report_sink.words[k], exp_word(k));
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #100000;
      error_cnt++;
      summarize();
   end
   initial
   begin
      resetn_i <= 1'b0;
      {reg_wr_i, reg_rd_i, cmd_req_i, trig_fire_i, slow} <= '0;
      {reg_addr_i, reg_wdata_i, cmd_src_i, trig_cause_i} <= '0;
      {start_evt1_i, start_evt2_i, clocks_gated_i, deep_idle_i} <= 4'h8;
      live_i <= {32'hc0de_0001, 1'b1, 56'h12_3456_789a_bcde};
      for (int i = 0; i < 8; i++)
      begin
         if (i < NAGG)
            agg_cnt_i[i*32+:32] <= 32'ha000_0000 + i;
         bool_cnt_i[i*32+:32] <= 32'hb000_0000 + i;
         cust_cnt_i[i*32+:32] <= 32'hc000_0000 + i;
      end
      {ctx_mode, ccs_sel, thr1, thr2, nexp} <= '0;
      repeat (4) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      reg_rd(CTRL_OFS, a);
      check(a, 32'h0000_0001);
      reg_rd(TRIG_OFS, a);
      check(a, 32'h0000_0000);
      reg_wr(8'h10, 32'hffff_ffff);
      reg_rd(8'h10, a);
      check(a, 32'h0000_0000);
      reg_wr(TRIG_OFS, 32'h0000_0002);
      thr2 = 1'b1;
      reg_rd(TRIG_OFS, a);
      check(a, 32'h0000_0002);
      // Two reads two cycles apart, then frozen under each hold input
      reg_rd(TICK_OFS, a);
      reg_rd(TICK_OFS, b);
      check(b, a + 32'h2);
      clocks_gated_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      reg_rd(TICK_OFS, a);
      repeat (5) @(posedge sys_clk_i);
      reg_rd(TICK_OFS, b);
      check(b, a);
      clocks_gated_i <= 1'b0;
      deep_idle_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      reg_rd(TICK_OFS, a);
      repeat (5) @(posedge sys_clk_i);
      reg_rd(TICK_OFS, tick_exp);
      check(tick_exp, a);
      // Every requester class and index, reserved ones included
      for (int c = 0; c < 5; c++)
         for (int i = 0; i < 8; i++)
         begin
            r = '{req_class_e'(c), 3'(i), 2'(3 - i % 4), 11'h5a5 + 11'(i)};
            live_i.context_valid <= i[0];
            send_cmd(r);
            get_rec(mk_hdr(r, 7'h00, 1'b0));
         end
      reg_wr(CTRL_OFS, 32'h0000_000d);
      {ctx_mode, ccs_sel} = 3'h6;
      reg_rd(CTRL_OFS, a);
      check(a, 32'h0000_000d);
      // Each cause bit, then both internal triggers together
      for (int j = 0; j < 8; j++)
      begin
         send_trig(j < 7 ? 7'(1 << j) : 7'h06);
         get_rec(mk_hdr('0, j < 7 ? 7'(1 << j) : 7'h06, 1'b0));
      end
      reg_wr(TRIG_OFS, 32'h0000_0006);
      get_rec(mk_hdr('0, 7'h40, 1'b0));
      reg_rd(TRIG_OFS, a);
      check(a, 32'h0000_0002);
      // Second request lands while the first record is still streaming
      slow <= 1'b1;
      r = '{REQ_HOST, 3'h0, 2'h0, 11'h000};
      send_cmd(r);
      repeat (3) @(posedge sys_clk_i);
      send_cmd('{REQ_SHADER, 3'h4, 2'h0, 11'h000});
      get_rec(mk_hdr(r, 7'h00, 1'b0));
      get_rec(mk_hdr('{REQ_SHADER, 3'h4, 2'h0, 11'h000}, 7'h00, 1'b1));
      slow <= 1'b0;
      reg_wr(CTRL_OFS, 32'h0000_0000);
      send_cmd(r);
      repeat (6) @(posedge sys_clk_i);
      check(busy_o, 1'b0);
      check(u_mem_report_sink.nrec, nexp);
      summarize();
   end
endmodule // tb
`default_nettype wire
